// *** src/emp_consts.svh ***
// Purpose: constants for the emergency message producer
// Assumes: included by the codec, history and producer design files, not by the package
// Notes: offsets are object-dictionary indices
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH

`define EMP_OD_FAULT_SUMMARY 16'h1001
`define EMP_OD_HISTORY 16'h1003
`define EMP_OD_EMCY_ID 16'h1014
`define EMP_HIST_DEPTH 3'h5
`define EMP_FUNC_EMCY 4'h1
`define EMP_ID_INVALID_BIT 31
`define EMP_ID_EXT_BIT 29
`define EMP_FSB_MASK 8'h91
`define EMP_FRAME_LEN 4'h8
`define EMP_CODE_NONE 16'h0000
`define EMP_CODE_CANCTRL 16'h1000
`define EMP_CODE_ACCESS 16'h5000
`define EMP_CODE_OVERRUN 16'h8110
`define EMP_CODE_GUARD 16'h8130
`define EMP_CODE_BUSOFF 16'h8140
`define EMP_CODE_PDOLEN 16'h8210
`define EMP_CODE_RESET 16'hff00
`define EMP_REG_HARD 8'h81
`define EMP_REG_COMM 8'h11
`define EMP_REG_RESET 8'h80

`endif

// *** src/emp_pkg.sv ***
// Purpose: types for the emergency message producer
// Assumes: self-contained; values are literals, emp_consts.svh is not included
// Notes: fault indices match the manufacturer first byte
package emp_pkg;

  typedef enum logic [3:0] {
    EMP_F_NONE = 4'h0,
    EMP_F_CANCTRL = 4'h1,
    EMP_F_NVMEM = 4'h2,
    EMP_F_SERIAL = 4'h3,
    EMP_F_RXOVR = 4'h4,
    EMP_F_TXOVR = 4'h5,
    EMP_F_CANOVR = 4'h6,
    EMP_F_GUARD = 4'h7,
    EMP_F_BUSOFF = 4'h8,
    EMP_F_PDOLEN = 4'h9,
    EMP_F_RESET = 4'ha
  } emp_fault_e;

  typedef struct packed {
    logic [15:0] code;
    logic [7:0] summary;
    logic [39:0] mfr;
  } emp_entry_s;

  typedef struct packed {
    logic [31:0] id;
    logic [3:0] len;
    logic [63:0] data;
  } emp_frame_s;

  typedef enum logic [2:0] {
    EMP_S_IDLE = 3'b001,
    EMP_S_SEND = 3'b010,
    EMP_S_LOG = 3'b100
  } emp_state_e;

endpackage

// *** src/emp_codec.sv ***
// Purpose: maps a fault index to its emergency entry
// Assumes: purely combinational
// Notes: unknown indices encode as the no-error entry
`timescale 1ns/1ns
`include "emp_consts.svh"
module emp_codec import emp_pkg::*; (
  input wire logic [3:0] fault,
  output emp_entry_s entry
);
  always_comb begin
    entry = '0;
    entry.mfr = {fault, 36'h0};
    entry.mfr[39:32] = {4'h0, fault};
    case (fault)
      EMP_F_CANCTRL: begin
        entry.code = `EMP_CODE_CANCTRL;
        entry.summary = `EMP_REG_HARD;
      end
      EMP_F_NVMEM, EMP_F_SERIAL: begin
        entry.code = `EMP_CODE_ACCESS;
        entry.summary = `EMP_REG_HARD;
      end
      EMP_F_RXOVR, EMP_F_TXOVR, EMP_F_CANOVR: begin
        entry.code = `EMP_CODE_OVERRUN;
        entry.summary = `EMP_REG_COMM;
      end
      EMP_F_GUARD: begin
        entry.code = `EMP_CODE_GUARD;
        entry.summary = `EMP_REG_COMM;
      end
      EMP_F_BUSOFF: begin
        entry.code = `EMP_CODE_BUSOFF;
        entry.summary = `EMP_REG_COMM;
      end
      EMP_F_PDOLEN: begin
        entry.code = `EMP_CODE_PDOLEN;
        entry.summary = `EMP_REG_COMM;
      end
      EMP_F_RESET: begin
        entry.code = `EMP_CODE_RESET;
        entry.summary = `EMP_REG_RESET;
      end
      default: begin
        entry = '0;
      end
    endcase
    entry.summary = entry.summary & `EMP_FSB_MASK;
  end
endmodule // emp_codec

// *** src/emp_history.sv ***
// Purpose: five-deep error history, newest at sub-index 1
// Assumes: push is a one-cycle pulse
// Notes: sub-index 0 reads the number of held entries
`timescale 1ns/1ns
`include "emp_consts.svh"
module emp_history import emp_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic push,
  input wire emp_entry_s entry,
  input wire logic [2:0] sub,
  output logic [31:0] rdata
);
  emp_entry_s hist_reg [1:5];
  logic [2:0] count_reg;

  genvar g;
  generate
    for (g = 1; g <= 5; g++) begin : g_slot
      // Slot 1 has no neighbour below, so it loads the new entry instead
      if (g == 1) begin : g_head
        always_ff @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            hist_reg[g] <= '0;
          end else if (push) begin
            hist_reg[g] <= entry;
          end
        end
      end else begin : g_tail
        always_ff @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            hist_reg[g] <= '0;
          end else if (push) begin
            hist_reg[g] <= hist_reg[g-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 3'h0;
    end else if (push && count_reg != `EMP_HIST_DEPTH) begin
      count_reg <= count_reg + 3'h1;
    end
  end

  // Entry word: code in the low half, summary byte and first mfr byte above
  always_comb begin
    rdata = 32'h0;
    if (sub == 3'h0) begin
      rdata = {29'h0, count_reg};
    end else if (sub <= count_reg) begin
      rdata = {hist_reg[sub].mfr[39:32], hist_reg[sub].summary, hist_reg[sub].code};
    end
  end
endmodule // emp_history

// *** src/emp_producer.sv ***
// Purpose: builds and sends emergency frames for detected faults
// Assumes: fault_valid/fault_id come from on-chip detectors on clk
// Notes: one fault accepted at a time; fault_ready stalls the rest
`timescale 1ns/1ns
`include "emp_consts.svh"
module emp_producer import emp_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [6:0] node_id,
  input wire logic fault_valid,
  input wire logic [3:0] fault_id,
  output logic fault_ready,
  input wire logic pdo_rx_valid,
  input wire logic [3:0] pdo_rx_len,
  input wire logic [3:0] pdo_map_len,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [2:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output emp_frame_s tx_frame,
  output logic [7:0] fault_summary
);
  emp_state_e state_reg;
  logic [31:0] emcy_id_reg;
  logic id_custom_reg;
  logic [3:0] pend_reg;
  logic pend_valid_reg;
  logic [3:0] cur_fault_reg;
  logic len_err_reg;
  emp_entry_s cur_entry;
  emp_entry_s log_entry_reg;
  logic hist_push;
  logic [31:0] hist_rdata;
  logic [31:0] id_now;
  logic id_wr;
  logic [31:0] id_wr_val;

  emp_codec u_codec (
    .fault(cur_fault_reg),
    .entry(cur_entry)
  );

  emp_history u_hist (
    .clk(clk),
    .rstn(rstn),
    .push(hist_push),
    .entry(log_entry_reg),
    .sub(od_sub),
    .rdata(hist_rdata)
  );

  // Identifier follows the node number until the master writes one
  always_comb begin
    id_now = {21'h0, `EMP_FUNC_EMCY, node_id};
    if (id_custom_reg) begin
      id_now = emcy_id_reg;
    end
  end

  assign id_wr = od_wr && od_index == `EMP_OD_EMCY_ID;

  // Bit 30 reserved; upper id bits cleared in 11-bit mode
  always_comb begin
    id_wr_val = od_wdata & 32'hbfffffff;
    if (!od_wdata[`EMP_ID_EXT_BIT]) begin
      id_wr_val[28:11] = 18'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      emcy_id_reg <= 32'h0;
      id_custom_reg <= 1'b0;
    end else if (id_wr) begin
      emcy_id_reg <= id_wr_val;
      id_custom_reg <= 1'b1;
    end
  end

  // Length check on received process data; the detector pulse wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      len_err_reg <= 1'b0;
    end else if (pdo_rx_valid && pdo_rx_len != pdo_map_len) begin
      len_err_reg <= 1'b1;
    end else if (len_err_reg && !pend_valid_reg && !(fault_valid && fault_ready)) begin
      len_err_reg <= 1'b0;
    end
  end

  // One-entry holding stage so a fault is never lost while a frame is out
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 4'h0;
      pend_valid_reg <= 1'b0;
    end else if (!pend_valid_reg && fault_valid && fault_ready) begin
      pend_reg <= fault_id;
      pend_valid_reg <= 1'b1;
    end else if (!pend_valid_reg && len_err_reg) begin
      pend_reg <= EMP_F_PDOLEN;
      pend_valid_reg <= 1'b1;
    end else if (pend_valid_reg && state_reg == EMP_S_IDLE) begin
      pend_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_ready <= 1'b0;
    end else begin
      // Held low while a length fault waits, so no request meets a full stage
      fault_ready <= !pend_valid_reg && !(fault_valid && fault_ready) && !len_err_reg;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= EMP_S_IDLE;
      cur_fault_reg <= 4'h0;
    end else begin
      case (state_reg)
        EMP_S_IDLE: begin
          if (pend_valid_reg) begin
            cur_fault_reg <= pend_reg;
            if (!id_now[`EMP_ID_INVALID_BIT]) begin
              state_reg <= EMP_S_SEND;
            end
          end
        end
        EMP_S_SEND: begin
          if (tx_valid && tx_ready) begin
            state_reg <= EMP_S_LOG;
          end
        end
        EMP_S_LOG: begin
          state_reg <= EMP_S_IDLE;
        end
        default: begin
          state_reg <= EMP_S_IDLE;
        end
      endcase
    end
  end

  // Frame output held stable until the controller takes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_frame <= '0;
    end else if (state_reg == EMP_S_SEND && !tx_valid) begin
      tx_valid <= 1'b1;
      tx_frame.id <= id_now;
      tx_frame.len <= `EMP_FRAME_LEN;
      tx_frame.data <= {cur_entry.code[7:0], cur_entry.code[15:8],
                        cur_entry.summary, cur_entry.mfr};
    end else if (tx_valid && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      log_entry_reg <= '0;
    end else if (state_reg == EMP_S_SEND && !tx_valid) begin
      log_entry_reg <= cur_entry;
    end
  end

  assign hist_push = state_reg == EMP_S_LOG;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_summary <= 8'h0;
    end else if (hist_push) begin
      fault_summary <= log_entry_reg.summary & `EMP_FSB_MASK;
    end
  end

  // Object dictionary read port, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      od_rdata <= 32'h0;
    end else begin
      case (od_index)
        `EMP_OD_FAULT_SUMMARY: od_rdata <= {24'h0, fault_summary};
        `EMP_OD_HISTORY: od_rdata <= hist_rdata;
        `EMP_OD_EMCY_ID: od_rdata <= id_now;
        default: od_rdata <= 32'h0;
      endcase
    end
  end
endmodule // emp_producer

// *** bench/emp_producer_asserts.sv ***
// Purpose: port-level checks of the emergency producer
// Assumes: one clock domain, bound to emp_producer
// Notes: tracks the last identifier write itself
`timescale 1ns/1ns
module emp_producer_asserts import emp_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [6:0] node_id,
  input wire logic fault_valid,
  input wire logic fault_ready,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [31:0] od_wdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire emp_frame_s tx_frame,
  input wire logic [7:0] fault_summary
);
  logic seen_reg;
  logic [31:0] cfg_reg;
  // Mirrors the stored identifier so the frame id can be judged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_reg <= 1'b0;
      cfg_reg <= 32'h0;
    end else if (od_wr && od_index == 16'h1014) begin
      seen_reg <= 1'b1;
      cfg_reg <= {od_wdata[31], 1'b0, od_wdata[29],
        od_wdata[29] ? od_wdata[28:11] : 18'h0, od_wdata[10:0]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_frame_len: assert property (tx_valid |-> tx_frame.len == 4'h8)
    else $error("frame length wrong");
  a_tail_zero: assert property (tx_valid |-> tx_frame.data[31:0] == 32'h0)
    else $error("frame tail not zero");
  a_summary_bits: assert property ((fault_summary & 8'h6e) == 8'h0)
    else $error("unused summary bit set");
  a_frame_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("frame dropped before taken");
  a_send_delay: assert property (fault_valid && fault_ready && !cfg_reg[31] |-> ##3 tx_valid)
    else $error("frame late");
  a_drop_invalid: assert property (fault_valid && fault_ready && cfg_reg[31] |=> !tx_valid [*8])
    else $error("frame sent while disabled");
  a_id_default: assert property (tx_valid && !seen_reg |-> tx_frame.id == {21'h0, 4'h1, node_id})
    else $error("default id wrong");
  a_id_config: assert property (tx_valid && seen_reg |-> tx_frame.id == cfg_reg)
    else $error("configured id wrong");
  a_summary_copy: assert property (tx_valid && tx_ready |->
    ##2 fault_summary == ($past(tx_frame.data[47:40], 2) & 8'h91))
    else $error("summary not copied");
  a_code_order: assert property (tx_valid && tx_frame.data[39:32] == 8'h09 |->
    tx_frame.data[63:48] == 16'h1082)
    else $error("code byte order wrong");
endmodule // emp_producer_asserts
bind emp_producer emp_producer_asserts CHK (.clk, .rstn, .node_id, .fault_valid, .fault_ready,
  .od_wr, .od_index, .od_wdata, .tx_valid, .tx_ready, .tx_frame, .fault_summary);

// *** bench/emp_can_sink.sv ***
// Purpose: CAN controller model that takes offered frames
// Assumes: lat sets the stall before each take
// Notes: ready rises only while a frame is offered
`timescale 1ns/1ns
module emp_can_sink import emp_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [15:0] frames
);
  logic [3:0] wait_reg;
  // Ready drops right after the handshake so no frame is taken twice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 4'h0;
      tx_ready <= 1'b0;
    end else if (tx_valid && !tx_ready) begin
      wait_reg <= wait_reg + 4'h1;
      tx_ready <= (wait_reg >= lat);
    end else begin
      wait_reg <= 4'h0;
      tx_ready <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) frames <= 16'h0;
    else if (tx_valid && tx_ready) frames <= frames + 16'h1;
  end
endmodule // emp_can_sink

// *** bench/tb_emp_producer.sv ***
// Purpose: self-checking bench for emp_producer
// Assumes: one clock, sink model on the frame port
// Notes: random values from an 8-bit shift register seeded at 40
`timescale 1ns/1ns
module tb_emp_producer import emp_pkg::*; ;
  logic clk, rstn, fault_valid, fault_ready, pdo_rx_valid, od_wr, tx_valid, tx_ready;
  logic [6:0] node_id;
  logic [3:0] fault_id, pdo_rx_len, pdo_map_len, lat;
  logic [15:0] od_index, frames, f0;
  logic [2:0] od_sub;
  logic [31:0] od_wdata, od_rdata, cur_id;
  logic [7:0] fault_summary, seed, fsel;
  emp_frame_s tx_frame;
  logic [31:0] hist[$];
  int num_errors, compares;
  emp_producer DUT (.clk, .rstn, .node_id, .fault_valid, .fault_id, .fault_ready,
    .pdo_rx_valid, .pdo_rx_len, .pdo_map_len, .od_wr, .od_index, .od_sub, .od_wdata,
    .od_rdata, .tx_valid, .tx_ready, .tx_frame, .fault_summary);
  emp_can_sink SINK (.clk, .rstn, .lat, .tx_valid, .tx_ready, .frames);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function logic [15:0] ecode(input logic [3:0] f);
    case (f)
      4'h1: return 16'h1000;
      4'h2, 4'h3: return 16'h5000;
      4'h4, 4'h5, 4'h6: return 16'h8110;
      4'h7: return 16'h8130;
      4'h8: return 16'h8140;
      4'h9: return 16'h8210;
      4'ha: return 16'hff00;
      default: return 16'h0000;
    endcase
  endfunction
  function logic [7:0] esumm(input logic [3:0] f);
    if (f == 4'h0 || f > 4'ha) return 8'h00;
    if (f < 4'h4) return 8'h81;
    return (f == 4'ha) ? 8'h80 : 8'h11;
  endfunction
  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [103:0] e, input logic [103:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wt(input logic v);
    int i;
    for (i = 0; i < 40 && tx_valid !== v; i++) step(1);
    if (i == 40) begin
      num_errors++;
      results();
    end
  endtask
  task req(input logic [3:0] f);
    int i;
    seed = nxt(seed);
    lat = {1'b0, seed[2:0]};
    fault_id = f;
    fault_valid = 1'b1;
    for (i = 0; i < 40 && fault_ready !== 1'b1; i++) step(1);
    if (i == 40) begin
      num_errors++;
      results();
    end
    step(1);
    fault_valid = 1'b0;
  endtask
  task expect_frame(input logic [3:0] f);
    logic [15:0] c;
    logic [7:0] s;
    c = ecode(f);
    s = esumm(f);
    wt(1'b1);
    chk("frame", {cur_id, 4'h8, c[7:0], c[15:8], s, 4'h0, f, 32'h0}, tx_frame);
    wt(1'b0);
    step(3);
    chk("summary", s & 8'h91, fault_summary);
    hist.push_front({4'h0, f, s, c});
    if (hist.size() > 5) hist.pop_back();
  endtask
  task odw(input logic [31:0] d);
    od_index = 16'h1014;
    od_wdata = d;
    od_wr = 1'b1;
    step(1);
    od_wr = 1'b0;
    cur_id = {d[31], 1'b0, d[29], d[29] ? d[28:11] : 18'h0, d[10:0]};
  endtask
  task odr(input logic [15:0] x, input logic [2:0] s, input logic [31:0] e);
    od_index = x;
    od_sub = s;
    step(2);
    chk("object", e, od_rdata);
  endtask
  initial begin
    rstn = 1'b0;
    {fault_valid, pdo_rx_valid, od_wr, fault_id, pdo_rx_len, lat} = 0;
    {od_index, od_sub, od_wdata} = 0;
    pdo_map_len = 4'h8;
    node_id = 7'h2a;
    seed = 8'h28;
    num_errors = 0;
    compares = 0;
    cur_id = {21'h0, 4'h1, 7'h2a};
    step(6);
    rstn = 1'b1;
    step(2);
    odr(16'h1003, 3'h0, 32'h0);
    for (int f = 0; f < 11; f++) begin
      req(f[3:0]);
      expect_frame(f[3:0]);
    end
    odr(16'h1003, 3'h0, 32'h5);
    for (int s = 1; s < 6; s++) odr(16'h1003, s[2:0], hist[s-1]);
    odr(16'h1001, 3'h0, 32'h80);
    // Length mismatch must raise the fault; a matching length must not
    pdo_rx_len = 4'h1;
    pdo_rx_valid = 1'b1;
    step(1);
    pdo_rx_valid = 1'b0;
    expect_frame(4'h9);
    odr(16'h1003, 3'h1, hist[0]);
    f0 = frames;
    pdo_rx_len = 4'h8;
    pdo_rx_valid = 1'b1;
    step(1);
    pdo_rx_valid = 1'b0;
    step(12);
    chk("frames", f0, frames);
    for (int k = 0; k < 2; k++) begin
      odw({2'b01, k[0], 5'h1f, seed, seed, seed});
      odr(16'h1014, 3'h0, cur_id);
      repeat (4) begin
        fsel = seed % 8'h0b;
        req(fsel[3:0]);
        expect_frame(fsel[3:0]);
      end
    end
    f0 = frames;
    odw(32'h8000_0081);
    req(4'h1);
    step(10);
    chk("frames", f0, frames);
    chk("summary", hist[0][23:16] & 8'h91, fault_summary);
    results();
  end
endmodule // tb_emp_producer
